// >>> src/idfc_map.vh
// Constants for the identification block and feature command block
// How it works
// - Word 255 holds A5 and zeroing checksum
// - Word 0 flags fixed/removable, ATA, valid
// - Default geometry words and capacity words
// - Word 2 holds one of four codes when requested, else zero
// - Word 49 sets LBA, DMA, bit 11
// - Word 50 reads 01 on top, timer bit
// - Word 51 upper byte reports PIO mode 2
// - Word 53 validates words 54-58, 64-70, 88
// - Word 59 multiple enable and block count
// - Word 63 selected and supported DMA modes
// - Word 64 reports PIO modes 3, 4
// - Word 80 flags major revisions 2 to 5
// - Words 82, 83 carry support flags
// - Words 85, 86 track enabled features
// - Words 84, 87 top bits and logging flags
// - Word 88 current and supported Ultra modes
// - Word 93 top bits and cable bit
// - Word 93 device-number method field
// - Word 93 device 0 signal-seen bits
// - Word 128 reports security state
// - Feature command busy, store code, interrupt
// - Bad feature code aborts the command
// - Identify prepares block, sets DRQ, interrupt
// - Cache enable/disable subcommand codes
`ifndef IDFC_MAP_VH
`define IDFC_MAP_VH
`define IDFC_OFF_CMD 12'h000
`define IDFC_OFF_STAT 12'h004
`define IDFC_OFF_CFG 12'h008
`define IDFC_OFF_CAP 12'h00c
`define IDFC_OFF_DATA 12'h010
`define IDFC_CFG_RST 16'h0004
`define IDFC_OP_IDENT 8'hec
`define IDFC_OP_IDDMA 8'hee
`define IDFC_OP_FEAT 8'hef
`define IDFC_OP_MULT 8'hc6
`define IDFC_FR_WC_EN 8'h02
`define IDFC_FR_WC_DIS 8'h82
`define IDFC_FR_RC_EN 8'haa
`define IDFC_FR_RC_DIS 8'h55
`define IDFC_FR_XFER 8'h03
`define IDFC_FR_APM_EN 8'h05
`define IDFC_FR_APM_DIS 8'h85
`define IDFC_FR_AAM_EN 8'h42
`define IDFC_FR_AAM_DIS 8'hc2
`define IDFC_FR_REV_DIS 8'h66
`define IDFC_FR_REV_EN 8'hcc
`define IDFC_SC_PIO 5'h01
`define IDFC_SC_MDMA 5'h04
`define IDFC_SC_UDMA 5'h08
`define IDFC_SIG 8'ha5
`define IDFC_W0_BASE 16'h041a
`define IDFC_W0_REM 16'h0080
`define IDFC_W0_FIX 16'h0040
`define IDFC_W1 16'h3fff
`define IDFC_W3 16'h0010
`define IDFC_W6 16'h003f
`define IDFC_W2_A 16'h37c8
`define IDFC_W2_B 16'h738c
`define IDFC_W2_C 16'h8c73
`define IDFC_W2_D 16'hc837
`define IDFC_W20 16'h0003
`define IDFC_W22 16'h0004
`define IDFC_W47 16'h8010
`define IDFC_W49 16'h0b00
`define IDFC_W50 16'h4000
`define IDFC_W51 16'h0200
`define IDFC_W53 16'h0007
`define IDFC_W57 16'hfc10
`define IDFC_W58 16'h00fb
`define IDFC_W63_SUP 8'h07
`define IDFC_W64 16'h0003
`define IDFC_W65 16'h0078
`define IDFC_W67 16'h00f0
`define IDFC_W80 16'h003c
`define IDFC_W82 16'h346b
`define IDFC_W83 16'h7628
`define IDFC_W84 16'h4003
`define IDFC_W85_BASE 16'h340b
`define IDFC_W86_BASE 16'h3400
`define IDFC_W88_SUP 8'h3f
`define IDFC_ASCII 16'h2020
`define IDFC_CAP_RST 28'h4a85300
`endif

// >>> src/idfc_top.v
// Identification block builder and feature command handler, APB slave
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`include "idfc_map.vh"
module idfc_top #(
  parameter [27:0] CAP_DEFAULT = `IDFC_CAP_RST
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Task-file status
  output reg bsy_o,
  output reg drq_o,
  output reg intrq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PREP = 2'd1;
  localparam ST_XFER = 2'd2;
  localparam ST_FEAT = 2'd3;
  localparam [7:0] LAST_SCAN = 8'd254;
  localparam [7:0] LAST_WORD = 8'd255;

  reg [1:0] state;
  reg [7:0] scan;
  reg [7:0] ptr;
  reg [7:0] sum;
  reg [7:0] chk;
  reg [7:0] op;
  reg [7:0] fr;
  reg [7:0] sc;
  reg [7:0] last_fr;
  reg err;
  reg wc_en;
  reg rc_en;
  reg aam_en;
  reg apm_en;
  reg rev_en;
  reg [2:0] pio_mode;
  reg [2:0] mdma_sel;
  reg [5:0] udma_sel;
  reg mult_en;
  reg [7:0] mult_cnt;
  reg [15:0] cfg;
  reg [27:0] cap;
  reg [7:0] idx;
  reg [15:0] word;
  reg [31:0] rdata;
  reg rd_err;
  reg next_abort;
  wire access;
  wire done;
  wire [7:0] next_sum;

  // Config fields
  wire cfg_rem = cfg[0];
  wire [1:0] cfg_w2 = cfg[2:1];
  wire cfg_dev1 = cfg[3];
  wire [1:0] cfg_meth = cfg[5:4];
  wire cfg_dasp = cfg[6];
  wire cfg_pdiag = cfg[7];
  wire cfg_diag_ok = cfg[8];
  wire cfg_stby = cfg[9];
  wire cfg_stby_min = cfg[10];
  wire [5:0] cfg_sec = {3'b000, cfg[13:11]};
  wire cfg_sec_lvl = cfg[14];
  wire cfg_w2_req = cfg[15];

  assign access = psel_i & penable_i & ~pready_o;
  assign done = psel_i & penable_i & pready_o;
  // words frozen while the block is in use
  wire cfg_lock = bsy_o | drq_o;

  // Word source
  always @* begin
    idx = (state == ST_PREP) ? scan : ptr;
    word = 16'h0000;
    case (idx)
      8'd0: word = `IDFC_W0_BASE | (cfg_rem ? `IDFC_W0_REM : `IDFC_W0_FIX);
      8'd1: word = `IDFC_W1;
      8'd2: begin
        case (cfg_w2)
          2'd0: word = `IDFC_W2_A;
          2'd1: word = `IDFC_W2_B;
          2'd2: word = `IDFC_W2_C;
          default: word = `IDFC_W2_D;
        endcase
        if (!cfg_w2_req)
          word = 16'h0000;
      end
      8'd3: word = `IDFC_W3;
      8'd6: word = `IDFC_W6;
      8'd20: word = `IDFC_W20;
      8'd22: word = `IDFC_W22;
      8'd47: word = `IDFC_W47;
      8'd49: word = `IDFC_W49 | {2'b00, cfg_stby, 13'h0000};
      8'd50: word = `IDFC_W50 | {15'h0000, cfg_stby_min};
      8'd51: word = `IDFC_W51;
      8'd52: word = `IDFC_W51;
      8'd53: word = `IDFC_W53;
      8'd54: word = `IDFC_W1;
      8'd55: word = `IDFC_W3;
      8'd56: word = `IDFC_W6;
      8'd57: word = `IDFC_W57;
      8'd58: word = `IDFC_W58;
      8'd59: word = {7'h00, mult_en, mult_cnt};
      8'd60: word = cap[15:0];
      8'd61: word = {4'h0, cap[27:16]};
      8'd63: word = {5'h00, mdma_sel, `IDFC_W63_SUP};
      8'd64: word = `IDFC_W64;
      8'd65: word = `IDFC_W65;
      8'd66: word = `IDFC_W65;
      8'd67: word = `IDFC_W67;
      8'd68: word = `IDFC_W65;
      8'd80: word = `IDFC_W80;
      8'd82: word = `IDFC_W82;
      8'd83: word = `IDFC_W83;
      8'd84: word = `IDFC_W84;
      8'd87: word = `IDFC_W84;
      8'd85: word = `IDFC_W85_BASE | {9'h000, rc_en, wc_en, 5'h00};
      8'd86: word = `IDFC_W86_BASE | {6'h00, aam_en, 5'h00, apm_en, 3'h0};
      8'd88: word = {2'b00, udma_sel, `IDFC_W88_SUP};
      8'd93: begin
        if (cfg_dev1)
          word = {3'b011, 1'b0, cfg_pdiag, cfg_meth, 1'b1, 8'h00};
        else
          word = {3'b011, 5'h00, 2'b00, cfg_dasp, cfg_pdiag, cfg_diag_ok,
                  cfg_meth, 1'b1};
      end
      8'd128: word = {7'h00, cfg_sec_lvl, 2'b00, cfg_sec};
      8'd255: word = {chk, `IDFC_SIG};
      default: begin
        if ((idx >= 8'd10 && idx <= 8'd19) || (idx >= 8'd23 && idx <= 8'd46))
          word = `IDFC_ASCII;
      end
    endcase
  end

  assign next_sum = sum + word[7:0] + word[15:8];

  // Feature code check
  always @* begin
    next_abort = 1'b0;
    case (fr)
      `IDFC_FR_WC_EN, `IDFC_FR_WC_DIS, `IDFC_FR_RC_EN, `IDFC_FR_RC_DIS,
      `IDFC_FR_APM_EN, `IDFC_FR_APM_DIS, `IDFC_FR_AAM_EN,
      `IDFC_FR_AAM_DIS, `IDFC_FR_REV_DIS, `IDFC_FR_REV_EN: next_abort = 1'b0;
      `IDFC_FR_XFER: begin
        case (sc[7:3])
          5'h00: next_abort = (sc[2:0] != 3'd0);
          `IDFC_SC_PIO: next_abort = (sc[2:0] > 3'd4);
          `IDFC_SC_MDMA: next_abort = (sc[2:0] > 3'd2);
          `IDFC_SC_UDMA: next_abort = (sc[2:0] > 3'd5);
          default: next_abort = 1'b1;
        endcase
      end
      default: next_abort = 1'b1;
    endcase
  end

  // Register read mux
  always @* begin
    rdata = 32'h00000000;
    rd_err = 1'b0;
    case (paddr_i)
      `IDFC_OFF_CMD: rdata = {8'h00, sc, fr, op};
      `IDFC_OFF_STAT: rdata = {16'h0000, last_fr, pio_mode, rev_en, err,
                               intrq_o, drq_o, bsy_o};
      `IDFC_OFF_CFG: rdata = {16'h0000, cfg};
      `IDFC_OFF_CAP: rdata = {4'h0, cap};
      `IDFC_OFF_DATA: rdata = {16'h0000, drq_o ? word : 16'h0000};
      default: rd_err = 1'b1;
    endcase
  end

  // APB answer, one wait cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access;
      if (access) begin
        prdata_o <= pwrite_i ? 32'h00000000 : rdata;
        pslverr_o <= rd_err | (pwrite_i && paddr_i == `IDFC_OFF_CMD &&
                     cfg_lock) |
                     (pwrite_i && paddr_i == `IDFC_OFF_CFG && cfg_lock) |
                     (pwrite_i && paddr_i == `IDFC_OFF_CAP && cfg_lock) |
                     (pwrite_i && paddr_i == `IDFC_OFF_STAT) |
                     (pwrite_i && paddr_i == `IDFC_OFF_DATA);
      end
    end
  end

  // Command engine
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      scan <= 8'h00;
      ptr <= 8'h00;
      sum <= 8'h00;
      chk <= 8'h00;
      op <= 8'h00;
      fr <= 8'h00;
      sc <= 8'h00;
      last_fr <= 8'h00;
      err <= 1'b0;
      wc_en <= 1'b1;
      rc_en <= 1'b1;
      aam_en <= 1'b0;
      apm_en <= 1'b1;
      rev_en <= 1'b0;
      pio_mode <= 3'd4;
      mdma_sel <= 3'b100;
      udma_sel <= 6'h00;
      mult_en <= 1'b0;
      mult_cnt <= 8'h00;
      cfg <= `IDFC_CFG_RST;
      cap <= CAP_DEFAULT;
      bsy_o <= 1'b0;
      drq_o <= 1'b0;
      intrq_o <= 1'b0;
    end else begin
      if (done && pwrite_i && !pslverr_o && paddr_i == `IDFC_OFF_CFG)
        cfg <= pwdata_i[15:0];
      if (done && pwrite_i && !pslverr_o && paddr_i == `IDFC_OFF_CAP)
        cap <= pwdata_i[27:0];
      // Status read acknowledges the interrupt
      if (done && !pwrite_i && paddr_i == `IDFC_OFF_STAT)
        intrq_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (done && pwrite_i && !pslverr_o &&
              paddr_i == `IDFC_OFF_CMD) begin
            op <= pwdata_i[7:0];
            fr <= pwdata_i[15:8];
            sc <= pwdata_i[23:16];
            bsy_o <= 1'b1;
            err <= 1'b0;
            intrq_o <= 1'b0;
            if (pwdata_i[7:0] == `IDFC_OP_IDENT ||
                pwdata_i[7:0] == `IDFC_OP_IDDMA) begin
              state <= ST_PREP;
              scan <= 8'h00;
              sum <= `IDFC_SIG;
            end else begin
              state <= ST_FEAT;
            end
          end
        end
        ST_PREP: begin
          sum <= next_sum;
          if (scan == LAST_SCAN) begin
            chk <= 8'h00 - next_sum;
            state <= ST_XFER;
            ptr <= 8'h00;
            bsy_o <= 1'b0;
            drq_o <= 1'b1;
            intrq_o <= 1'b1;
          end else begin
            scan <= scan + 8'd1;
          end
        end
        ST_XFER: begin
          if (done && !pwrite_i && paddr_i == `IDFC_OFF_DATA) begin
            ptr <= ptr + 8'd1;
            if (ptr == LAST_WORD) begin
              drq_o <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_FEAT: begin
          state <= ST_IDLE;
          bsy_o <= 1'b0;
          intrq_o <= 1'b1;
          if (op == `IDFC_OP_FEAT) begin
            last_fr <= fr;
            if (next_abort) begin
              err <= 1'b1;
            end else begin
              case (fr)
                `IDFC_FR_WC_EN: wc_en <= 1'b1;
                `IDFC_FR_WC_DIS: wc_en <= 1'b0;
                `IDFC_FR_RC_EN: rc_en <= 1'b1;
                `IDFC_FR_RC_DIS: rc_en <= 1'b0;
                `IDFC_FR_APM_EN: apm_en <= 1'b1;
                `IDFC_FR_APM_DIS: apm_en <= 1'b0;
                `IDFC_FR_AAM_EN: aam_en <= 1'b1;
                `IDFC_FR_AAM_DIS: aam_en <= 1'b0;
                `IDFC_FR_REV_EN: rev_en <= 1'b1;
                `IDFC_FR_REV_DIS: rev_en <= 1'b0;
                `IDFC_FR_XFER: begin
                  case (sc[7:3])
                    `IDFC_SC_MDMA: begin
                      mdma_sel <= 3'b001 << sc[1:0];
                      udma_sel <= 6'h00;
                    end
                    `IDFC_SC_UDMA: begin
                      udma_sel <= 6'h01 << sc[2:0];
                      mdma_sel <= 3'b000;
                    end
                    default: pio_mode <= sc[2:0];
                  endcase
                end
                default: err <= 1'b0;
              endcase
            end
          end else if (op == `IDFC_OP_MULT) begin
            case (sc)
              8'd2, 8'd4, 8'd8, 8'd16, 8'd32: begin
                mult_en <= 1'b1;
                mult_cnt <= sc;
              end
              8'd0, 8'd1: begin
                mult_en <= 1'b0;
                mult_cnt <= 8'h00;
              end
              default: begin
                mult_en <= 1'b0;
                mult_cnt <= 8'h00;
                err <= 1'b1;
              end
            endcase
          end else begin
            err <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // idfc_top

// >>> verification/idfc_monitor.sv
// Port checker for the identification block builder
`timescale 1ns/10ps
module idfc_monitor (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus side
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Status
  input wire bsy_o,
  input wire drq_o,
  input wire intrq_o
);
  wire done_ph = psel_i && penable_i && pready_o;
  wire rd_w = done_ph && !pwrite_i && paddr_i == 12'h010 && drq_o;
  reg [8:0] cnt;
  reg [7:0] acc;
  // Word pointer and byte sum
  always @(posedge clk_i) begin
    if (rst_i || !drq_o) begin
      cnt <= 9'h000;
      acc <= 8'h00;
    end else if (rd_w) begin
      cnt <= cnt + 9'h001;
      acc <= acc + prdata_o[7:0] + prdata_o[15:8];
    end
  end
  sequence s_cmd(op);
    done_ph && pwrite_i && paddr_i == 12'h000 && !pslverr_o &&
      pwdata_i[7:0] == op;
  endsequence
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_SIG:
    assert property (rd_w && cnt == 9'h0ff |-> prdata_o[7:0] == 8'ha5)
    else $error("signature byte wrong");
  AST_SUM:
    assert property (rd_w && cnt == 9'h0ff |->
      (acc + prdata_o[7:0] + prdata_o[15:8]) == 8'h00)
    else $error("block byte sum not zero");
  AST_W0:
    assert property (rd_w && cnt == 9'h000 |-> !prdata_o[15] &&
      !prdata_o[2] && (prdata_o[7] ^ prdata_o[6]))
    else $error("word 0 flags wrong");
  AST_GEOM:
    assert property (rd_w && cnt == 9'h001 |-> prdata_o[15:0] == 16'h3fff)
    else $error("cylinder word wrong");
  AST_W49:
    assert property (rd_w && cnt == 9'h031 |->
      (prdata_o[15:0] & 16'h0b00) == 16'h0b00)
    else $error("word 49 wrong");
  AST_W84:
    assert property (rd_w && (cnt == 9'h054 || cnt == 9'h057) |->
      prdata_o[15:14] == 2'h1)
    else $error("word 84 or 87 top bits wrong");
  AST_W88:
    assert property (rd_w && cnt == 9'h058 |-> prdata_o[7:0] == 8'h3f)
    else $error("word 88 support byte wrong");
  AST_FEAT:
    assert property (s_cmd(8'hef) |=> bsy_o ##1 (!bsy_o && intrq_o))
    else $error("feature command timing wrong");
  AST_IDENT:
    assert property (s_cmd(8'hec) |=> bsy_o [*8] ##[240:260]
      (drq_o && !bsy_o && intrq_o))
    else $error("identify did not finish in time");
  AST_END:
    assert property (rd_w && cnt == 9'h0ff |=> !drq_o)
    else $error("data request stayed after last word");
endmodule // idfc_monitor
bind idfc_top idfc_monitor idfc_monitor_i (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .bsy_o, .drq_o, .intrq_o);

// >>> verification/idfc_host.sv
// Host bus master issuing one register transfer per request
`timescale 1ns/10ps
module idfc_host (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bench request
  input wire go_i,
  input wire wr_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  output reg done_o = 1'b0,
  output reg err_o = 1'b0,
  output reg [31:0] rdata_o = 32'h0,
  // Bus side
  output reg psel_o = 1'b0,
  output reg penable_o = 1'b0,
  output reg pwrite_o = 1'b0,
  output reg [11:0] paddr_o = 12'h000,
  output reg [31:0] pwdata_o = 32'h0,
  input wire [31:0] prdata_i,
  input wire pready_i,
  input wire pslverr_i
);
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
    end else if (go_i && !psel_o) begin
      psel_o <= 1'b1;
      pwrite_o <= wr_i;
      paddr_o <= addr_i;
      pwdata_o <= wdata_i;
    end else if (psel_o && !penable_o) begin
      penable_o <= 1'b1;
    end else if (penable_o && pready_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      done_o <= 1'b1;
      rdata_o <= prdata_i;
      err_o <= pslverr_i;
      pwrite_o <= ~pwrite_o;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
    end
  end
endmodule // idfc_host

// >>> verification/tb_top.sv
// Bench for the identification block builder
`timescale 1ns/10ps
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg go = 1'b0;
  reg wr = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdata = 32'h0;
  wire psel, pen, pwr, prdy, pserr, bsy, drq, intrq, done, err;
  wire [11:0] paddr;
  wire [31:0] pwd, prd, rdata;
  integer error_cnt = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer seed = 32'h5fd3;
  integer i, sum;
  reg wc = 1'b1;
  reg rc = 1'b1;
  reg ap = 1'b1;
  reg [15:0] cfg, w;
  reg [27:0] cap;
  reg [7:0] fr [0:8];
  reg [15:0] code [0:3];
  initial forever #20 clk_i = ~clk_i;
  idfc_top idfc_top_i (.clk_i, .rst_i, .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(pserr), .bsy_o(bsy), .drq_o(drq),
    .intrq_o(intrq));
  idfc_host idfc_host_i (.clk_i, .rst_i, .go_i(go), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .done_o(done), .err_o(err),
    .rdata_o(rdata), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(paddr), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy),
    .pslverr_i(pserr));
  task chk(input [31:0] s, input [31:0] x);
    comparisons = comparisons + 1;
    if (s !== x) begin
      error_cnt = error_cnt + 1;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task give_verdict;
    $display("errors %0d of %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task xfer(input t, input [11:0] a, input [31:0] d);
    @(posedge clk_i);
    go <= 1'b1;
    wr <= t;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    go <= 1'b0;
    do @(posedge clk_i); while (done !== 1'b1);
  endtask
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  initial begin
    fr = '{8'h02, 8'h82, 8'h55, 8'haa, 8'h42, 8'h85, 8'hcc, 8'h77, 8'h03};
    code = '{16'h37c8, 16'h738c, 16'h8c73, 16'hc837};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 12'h008, 32'h0);
    chk(rdata, 32'h4);
    xfer(1'b0, 12'h00c, 32'h0);
    chk(rdata, 32'h4a85300);
    xfer(1'b0, 12'h014, 32'h0);
    chk(err, 1'b1);
    xfer(1'b1, 12'h004, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 9; i = i + 1) begin
      xfer(1'b1, 12'h000, {8'h00, 8'h45, fr[i], 8'hef});
      case (fr[i])
        8'h02: wc = 1'b1;
        8'h82: wc = 1'b0;
        8'haa: rc = 1'b1;
        8'h55: rc = 1'b0;
        8'h85: ap = 1'b0;
      endcase
      xfer(1'b0, 12'h004, 32'h0);
      chk(rdata & 32'hff0f, {16'h0, fr[i], 4'h0, fr[i] == 8'h77, 3'h4});
    end
    xfer(1'b1, 12'h000, 32'h000300c6);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rdata & 32'hf, 32'hc);
    xfer(1'b1, 12'h000, 32'h000800c6);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rdata & 32'hf, 32'h4);
    cfg = $random(seed) & 16'hfff7;
    if (cfg[5:4] == 2'h0) cfg[4] = 1'b1;
    cap = $random(seed);
    xfer(1'b1, 12'h008, {16'h0, cfg});
    xfer(1'b1, 12'h00c, {4'h0, cap});
    xfer(1'b0, 12'h008, 32'h0);
    chk(rdata, {16'h0, cfg});
    xfer(1'b1, 12'h000, 32'h0000_00ec);
    i = 0;
    while (drq !== 1'b1 && i < 400) begin
      @(posedge clk_i);
      i = i + 1;
    end
    xfer(1'b0, 12'h004, 32'h0);
    chk(rdata & 32'hf, 32'h6);
    xfer(1'b1, 12'h000, 32'h0000_00ef);
    chk(err, 1'b1);
    xfer(1'b1, 12'h008, 32'h0);
    chk(err, 1'b1);
    sum = 0;
    for (i = 0; i < 256; i = i + 1) begin
      xfer(1'b0, 12'h010, 32'h0);
      w = rdata[15:0];
      sum = sum + w[7:0] + w[15:8];
      case (i)
        0: chk(w & 16'h80c4, {8'h0, cfg[0], !cfg[0], 6'h0});
        1: chk(w, 16'h3fff);
        2: chk(w, cfg[15] ? code[cfg[2:1]] : 16'h0);
        3: chk(w, 16'h0010);
        6: chk(w, 16'h003f);
        49: chk(w & 16'h2b00, {2'h0, cfg[9], 13'h0b00});
        50: chk(w & 16'hc001, {15'h2000, cfg[10]});
        51: chk(w[15:8], 8'h02);
        53: chk(w[2:0], 3'h7);
        59: chk(w & 16'h01ff, 16'h0108);
        60: chk(w, cap[15:0]);
        61: chk(w, {4'h0, cap[27:16]});
        63: chk(w & 16'h0707, 16'h0007);
        64: chk(w[1:0], 2'h3);
        80: chk(w, 16'h003c);
        82: chk(w[10], 1'b1);
        83: chk(w[10:9], 2'h3);
        84, 87: chk(w[15:14], 2'h1);
        85: chk(w[6:5], {rc, wc});
        86: chk({w[9], w[3]}, {1'b1, ap});
        88: chk(w, 16'h203f);
        93: chk(w & 16'he03e, {3'h3, 7'h0, cfg[6], cfg[7], cfg[8],
          cfg[5:4], 1'b0});
        128: chk(w & 16'h013f, {7'h0, cfg[14], 5'h0, cfg[13:11]});
        255: chk(w[7:0], 8'ha5);
      endcase
    end
    chk(sum & 255, 32'h0);
    chk(drq, 1'b0);
    give_verdict;
  end
endmodule // tb_top
